// ### rtl/scm_top.v
// System clock source selection, external clock monitor, prescalers and AHB-Lite registers.
`timescale 1ns/1ps
`default_nettype none
`include "scm_defs.vh"

module scm_top #(
  parameter READY_EDGES = `SCM_READY_EDGES
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Oscillator pins
  input wire ext_clk_in,
  input wire pll_lock_in,
  // Oscillator enables
  output reg ext_osc_on,
  output reg pll_on,
  // Clock gate enables and source status
  output reg rc_gate,
  output reg ext_gate,
  output reg pll_gate,
  output reg [1:0] sys_src,
  output reg motor_control_timer_pll_sel,
  // Prescaler enables
  output wire ahb_tick,
  output wire apb2_tick,
  output wire apb1_tick,
  // Failure flag and interrupt
  output reg ext_fail_flag,
  output reg irq
);

  localparam integer MON_CYC = (`SCM_MON_TIMEOUT_NS * `SCM_CLK_MHZ) / 1000;
  localparam integer GAP_CYC = (`SCM_SW_GAP_NS * `SCM_CLK_MHZ + 999) / 1000;
  localparam [7:0] MON_LAST = MON_CYC[7:0] - 8'h01;
  localparam [7:0] GAP_LAST = GAP_CYC[7:0] - 8'h01;
  localparam [7:0] RDY_LAST = READY_EDGES[7:0] - 8'h01;

  localparam [1:0] SW_RUN = 2'b00;
  localparam [1:0] SW_OFF = 2'b01;
  localparam [1:0] SW_ON = 2'b10;

  // Pin synchronisers.
  reg ext_s1_r, ext_s2_r, ext_s3_r, ext_filt_r;
  reg lk_s1_r, lk_s2_r, lk_s3_r, lk_filt_r;
  // Software registers.
  reg mon_en_r, pll_ext_r;
  reg [1:0] src_req_r;
  reg [3:0] ahb_code_r, apb2_code_r, apb1_code_r;
  reg [`SCM_EV_W-1:0] stat_r, mask_r;
  // Monitor and sequencer state.
  reg [7:0] mon_cnt_r, rdy_cnt_r, gap_cnt_r;
  reg ext_ready_r;
  reg [1:0] sw_st_r, tgt_r;
  // Bus data phase.
  reg wr_pend_r;
  reg [7:0] wr_addr_r;

  wire ext_edge, lk_new, aphase, rd_clr, ext_fail, pll_fail, pll_up;
  wire [7:0] aofs;
  wire [`SCM_EV_W-1:0] ev, stat_nxt;
  reg [31:0] rdata_c;
  reg sw_done;

  // Source is usable only when its oscillator is known good.
  function src_ok;
    input [1:0] src;
    input ext_rdy;
    input pll_rdy;
    begin
      case (src)
        `SCM_SRC_RC: src_ok = 1'b1;
        `SCM_SRC_EXT: src_ok = ext_rdy;
        `SCM_SRC_PLL: src_ok = pll_rdy;
        default: src_ok = 1'b0;
      endcase
    end
  endfunction

  // A pin change counts only once the second and third stages agree.
  always @(posedge ref_clk) begin
    if (reset) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      ext_filt_r <= 1'b0;
      lk_s1_r <= 1'b0;
      lk_s2_r <= 1'b0;
      lk_s3_r <= 1'b0;
      lk_filt_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_clk_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      lk_s1_r <= pll_lock_in;
      lk_s2_r <= lk_s1_r;
      lk_s3_r <= lk_s2_r;
      if (ext_s2_r == ext_s3_r) begin
        ext_filt_r <= ext_s3_r;
      end
      if (lk_s2_r == lk_s3_r) begin
        lk_filt_r <= lk_s3_r;
      end
    end
  end

  assign ext_edge = (ext_s2_r == ext_s3_r) && (ext_s3_r != ext_filt_r);
  assign lk_new = (lk_s2_r == lk_s3_r) ? lk_s3_r : lk_filt_r;

  // Edge watchdog: the external clock is declared good after a run of edges and
  // dead when the gap between edges exceeds the timeout.
  // Monitoring cannot be switched off while the crystal feeds the core, directly or via the PLL.
  assign ext_fail = ext_ready_r && !ext_edge && (mon_cnt_r == MON_LAST) &&
    (mon_en_r || (sys_src == `SCM_SRC_EXT) || (pll_ext_r && (sys_src == `SCM_SRC_PLL)));

  always @(posedge ref_clk) begin
    if (reset) begin
      mon_cnt_r <= 8'h00;
      rdy_cnt_r <= 8'h00;
      ext_ready_r <= 1'b0;
    end else if (!ext_osc_on || ext_fail) begin
      mon_cnt_r <= 8'h00;
      rdy_cnt_r <= 8'h00;
      ext_ready_r <= 1'b0;
    end else if (ext_edge) begin
      mon_cnt_r <= 8'h00;
      if (rdy_cnt_r == RDY_LAST) begin
        ext_ready_r <= 1'b1;
      end else begin
        rdy_cnt_r <= rdy_cnt_r + 8'h01;
      end
    end else if (mon_cnt_r == MON_LAST) begin
      // Before the clock is qualified a long gap only restarts qualification.
      mon_cnt_r <= 8'h00;
      rdy_cnt_r <= 8'h00;
    end else begin
      mon_cnt_r <= mon_cnt_r + 8'h01;
    end
  end

  // The PLL fails when it loses lock, or when its external reference dies.
  assign pll_up = pll_on && lk_new && !lk_filt_r;
  assign pll_fail = pll_on && ((lk_filt_r && !lk_new) || (pll_ext_r && ext_fail));

  // Glitch-free switch: every gate is closed for a guard gap before the new
  // one opens, so no clock pulse is ever cut short.
  always @(posedge ref_clk) begin
    if (reset) begin
      sw_st_r <= SW_RUN;
      tgt_r <= `SCM_SRC_RC;
      gap_cnt_r <= 8'h00;
      sys_src <= `SCM_SRC_RC;
      rc_gate <= 1'b1;
      ext_gate <= 1'b0;
      pll_gate <= 1'b0;
      sw_done <= 1'b0;
    end else begin
      sw_done <= 1'b0;
      case (sw_st_r)
        SW_RUN: begin
          if ((ext_fail && (sys_src == `SCM_SRC_EXT)) ||
              (pll_fail && (sys_src == `SCM_SRC_PLL))) begin
            tgt_r <= `SCM_SRC_RC;
            rc_gate <= 1'b0;
            ext_gate <= 1'b0;
            pll_gate <= 1'b0;
            gap_cnt_r <= 8'h00;
            sw_st_r <= SW_OFF;
          end else if ((src_req_r != sys_src) &&
                       src_ok(src_req_r, ext_ready_r, pll_on && lk_filt_r)) begin
            tgt_r <= src_req_r;
            rc_gate <= 1'b0;
            ext_gate <= 1'b0;
            pll_gate <= 1'b0;
            gap_cnt_r <= 8'h00;
            sw_st_r <= SW_OFF;
          end
        end
        SW_OFF: begin
          if (ext_fail || pll_fail) begin
            tgt_r <= `SCM_SRC_RC;
          end
          if (gap_cnt_r == GAP_LAST) begin
            sw_st_r <= SW_ON;
          end else begin
            gap_cnt_r <= gap_cnt_r + 8'h01;
          end
        end
        SW_ON: begin
          if (!src_ok(tgt_r, ext_ready_r, pll_on && lk_filt_r)) begin
            tgt_r <= `SCM_SRC_RC;
          end else begin
            sys_src <= tgt_r;
            rc_gate <= (tgt_r == `SCM_SRC_RC);
            ext_gate <= (tgt_r == `SCM_SRC_EXT);
            pll_gate <= (tgt_r == `SCM_SRC_PLL);
            sw_done <= 1'b1;
            sw_st_r <= SW_RUN;
          end
        end
        default: begin
          sw_st_r <= SW_RUN;
        end
      endcase
    end
  end

  // Prescalers, one per bus domain.
  scm_clk_div u_div_ahb (
    .ref_clk(ref_clk),
    .reset(reset),
    .code(ahb_code_r),
    .tick(ahb_tick)
  );
  scm_clk_div u_div_apb2 (
    .ref_clk(ref_clk),
    .reset(reset),
    .code(apb2_code_r),
    .tick(apb2_tick)
  );
  scm_clk_div u_div_apb1 (
    .ref_clk(ref_clk),
    .reset(reset),
    .code(apb1_code_r),
    .tick(apb1_tick)
  );

  // The double-rate timer path is only safe while the AHB and APB2 clocks are fast.
  always @(posedge ref_clk) begin
    if (reset) begin
      motor_control_timer_pll_sel <= 1'b0;
    end else begin
      motor_control_timer_pll_sel <= (sys_src == `SCM_SRC_PLL) && pll_gate &&
        (({1'b0, ahb_code_r} + {1'b0, apb2_code_r}) <= 5'h01);
    end
  end

  // AHB-Lite slave with zero wait states; reads are answered from the
  // address phase so hrdata is a flip-flop in the data phase.
  assign aphase = hsel && htrans[1] && hready;
  assign aofs = {haddr[7:2], 2'b00};
  assign rd_clr = aphase && !hwrite && (aofs == `SCM_OFS_IRQ_STAT);

  always @* begin
    rdata_c = 32'h00000000;
    case (aofs)
      `SCM_OFS_CTRL: rdata_c[5:0] = {pll_ext_r, pll_on, src_req_r, mon_en_r, ext_osc_on};
      `SCM_OFS_DIV: rdata_c[11:0] = {apb1_code_r, apb2_code_r, ahb_code_r};
      `SCM_OFS_STAT: rdata_c[6:0] = {motor_control_timer_pll_sel, lk_filt_r,
                                     ext_ready_r, sw_st_r != SW_RUN, 1'b0, sys_src};
      `SCM_OFS_IRQ_STAT: rdata_c[`SCM_EV_W-1:0] = stat_r;
      `SCM_OFS_IRQ_MASK: rdata_c[`SCM_EV_W-1:0] = mask_r;
      default: rdata_c = 32'h00000000;
    endcase
  end

  // Events set sticky bits; a set in the clearing cycle survives the clear.
  assign ev[`SCM_EV_EXT_FAIL] = ext_fail;
  assign ev[`SCM_EV_PLL_FAIL] = pll_fail;
  assign ev[`SCM_EV_EXT_READY] = ext_edge && !ext_ready_r && ext_osc_on &&
                                 (rdy_cnt_r == RDY_LAST);
  assign ev[`SCM_EV_PLL_READY] = pll_up;
  assign ev[`SCM_EV_SWITCHED] = sw_done;
  assign stat_nxt = (stat_r & {`SCM_EV_W{!rd_clr}}) | ev;

  always @(posedge ref_clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      stat_r <= `SCM_MASK_RST;
      ext_fail_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= aphase && hwrite;
      if (aphase) begin
        wr_addr_r <= aofs;
      end
      if (aphase && !hwrite) begin
        hrdata <= rdata_c;
      end
      stat_r <= stat_nxt;
      ext_fail_flag <= stat_nxt[`SCM_EV_EXT_FAIL];
      irq <= |(stat_nxt & mask_r);
    end
  end

  // Software registers; a clock failure withdraws the request for the failed
  // source, external or PLL, so the sequencer does not switch straight back.
  always @(posedge ref_clk) begin
    if (reset) begin
      {pll_ext_r, pll_on, src_req_r, mon_en_r, ext_osc_on} <= `SCM_CTRL_RST;
      {apb1_code_r, apb2_code_r, ahb_code_r} <= `SCM_DIV_RST;
      mask_r <= `SCM_MASK_RST;
    end else begin
      if (wr_pend_r && (wr_addr_r == `SCM_OFS_CTRL)) begin
        ext_osc_on <= hwdata[`SCM_CTRL_EXT_ON];
        mon_en_r <= hwdata[`SCM_CTRL_MON_EN];
        src_req_r <= hwdata[`SCM_CTRL_SRC_HI:`SCM_CTRL_SRC_LO];
        pll_on <= hwdata[`SCM_CTRL_PLL_ON];
        pll_ext_r <= hwdata[`SCM_CTRL_PLL_EXT];
      end
      if ((ext_fail && (src_req_r == `SCM_SRC_EXT || pll_ext_r)) ||
          (pll_fail && src_req_r == `SCM_SRC_PLL)) begin
        src_req_r <= `SCM_SRC_RC;
      end
      if (wr_pend_r && (wr_addr_r == `SCM_OFS_DIV)) begin
        ahb_code_r <= hwdata[`SCM_DIV_AHB_LO+3:`SCM_DIV_AHB_LO];
        apb2_code_r <= hwdata[`SCM_DIV_APB2_LO+3:`SCM_DIV_APB2_LO];
        apb1_code_r <= hwdata[`SCM_DIV_APB1_LO+3:`SCM_DIV_APB1_LO];
      end
      if (wr_pend_r && (wr_addr_r == `SCM_OFS_IRQ_MASK)) begin
        mask_r <= hwdata[`SCM_EV_W-1:0];
      end
    end
  end

endmodule // scm_top
`default_nettype wire

// ### common/scm_defs.vh
// Register map, field positions, reset values and timing constants of the clock select block.
`ifndef SCM_DEFS_VH
`define SCM_DEFS_VH

// Register byte offsets.
`define SCM_OFS_CTRL 8'h00
`define SCM_OFS_DIV 8'h04
`define SCM_OFS_STAT 8'h08
`define SCM_OFS_IRQ_STAT 8'h0C
`define SCM_OFS_IRQ_MASK 8'h10

// Control register fields.
`define SCM_CTRL_EXT_ON 0
`define SCM_CTRL_MON_EN 1
`define SCM_CTRL_SRC_LO 2
`define SCM_CTRL_SRC_HI 3
`define SCM_CTRL_PLL_ON 4
`define SCM_CTRL_PLL_EXT 5

// Divider register fields, each a 4-bit power-of-two code.
`define SCM_DIV_AHB_LO 0
`define SCM_DIV_APB2_LO 4
`define SCM_DIV_APB1_LO 8

// Interrupt status and mask bits.
`define SCM_EV_EXT_FAIL 0
`define SCM_EV_PLL_FAIL 1
`define SCM_EV_EXT_READY 2
`define SCM_EV_PLL_READY 3
`define SCM_EV_SWITCHED 4
`define SCM_EV_W 5

// Clock source codes.
`define SCM_SRC_RC 2'h0
`define SCM_SRC_EXT 2'h1
`define SCM_SRC_PLL 2'h2

// Reset values.
`define SCM_CTRL_RST 6'h00
`define SCM_DIV_RST 12'h000
`define SCM_MASK_RST 5'h00

// Timing.
`define SCM_CLK_MHZ 40
`define SCM_MON_TIMEOUT_NS 1000
`define SCM_SW_GAP_NS 100
`define SCM_READY_EDGES 16
`define SCM_DIV_MAX 4'h9

`endif

// ### rtl/scm_clk_div.v
// Power-of-two prescaler that turns the reference clock into a one-cycle enable pulse.
`timescale 1ns/1ps
`default_nettype none
`include "scm_defs.vh"

module scm_clk_div #(
  parameter CW = 9
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Divide code, ratio is two to the power of the code, codes above 9 acting as 9
  input wire [3:0] code,
  // Enable pulse
  output reg tick
);

  reg [CW-1:0] cnt_r;
  wire [3:0] code_c;
  wire [CW-1:0] last_c;

  // Codes above the largest supported ratio saturate rather than wrap.
  assign code_c = (code > `SCM_DIV_MAX) ? `SCM_DIV_MAX : code;
  assign last_c = ({{(CW-1){1'b0}}, 1'b1} << code_c) - {{(CW-1){1'b0}}, 1'b1};

  always @(posedge ref_clk) begin
    if (reset) begin
      cnt_r <= {CW{1'b0}};
      tick <= 1'b0;
    end else if (cnt_r >= last_c) begin
      cnt_r <= {CW{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

endmodule // scm_clk_div
`default_nettype wire

// ### sim/scm_top_chk.sv
// Assertion checker for the clock select block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module scm_top_chk (
  // Clock, reset and bus
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  // Clock source outputs
  input wire logic ext_osc_on,
  input wire logic rc_gate,
  input wire logic ext_gate,
  input wire logic pll_gate,
  input wire logic [1:0] sys_src,
  input wire logic motor_control_timer_pll_sel,
  input wire logic ahb_tick,
  input wire logic apb2_tick,
  input wire logic apb1_tick,
  input wire logic ext_fail_flag,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire logic [2:0] gates = {rc_gate, ext_gate, pll_gate};

  a_reset_rc_src: assert property ($fell(reset) |-> rc_gate && sys_src == 2'h0)
    else $error("core clock not on the RC oscillator after reset");
  a_gates_onehot: assert property ($onehot0(gates))
    else $error("more than one clock gate open");
  a_switch_gap: assert property ($fell(gates != 3'h0) |-> (gates == 3'h0)[*3])
    else $error("new clock gate opened without a gap");
  a_fail_fallback: assert property ($rose(ext_fail_flag) && sys_src == 2'h1 |->
    ##[1:12] rc_gate && sys_src == 2'h0) else $error("no fallback to RC after failure");
  // A single-edge reset also clears the flag, so a fall right after reset is excused.
  a_flag_sticky: assert property ($fell(ext_fail_flag) && !$past(reset) |->
    $past(hsel && htrans[1] && !hwrite && haddr[7:0] == 8'h0C))
    else $error("failure flag cleared without a status read");
  a_pll_sel_src: assert property (motor_control_timer_pll_sel |->
    sys_src == 2'h2 && (pll_gate || $past(pll_gate)))
    else $error("motor timer on PLL clock without PLL source");
  a_ext_on_write: assert property (hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00
    ##1 1'b1 |=> ext_osc_on == $past(hwdata[0]))
    else $error("oscillator enable does not follow control write");
  a_tick_default: assert property ($fell(reset) |=>
    (ahb_tick && apb2_tick && apb1_tick)[*2]) else $error("prescaler not undivided after reset");

  c_fallback: cover property ($rose(ext_fail_flag) && sys_src == 2'h1);
  c_pll_sel: cover property ($rose(motor_control_timer_pll_sel));
  c_irq: cover property ($rose(irq));
endmodule // scm_top_chk

bind scm_top scm_top_chk scm_top_chk_i (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .ext_osc_on, .rc_gate, .ext_gate, .pll_gate, .sys_src,
  .motor_control_timer_pll_sel, .ahb_tick, .apb2_tick, .apb1_tick, .ext_fail_flag, .irq);
`default_nettype wire

// ### sim/scm_ext_src.sv
// Behavioural external crystal and PLL lock source for the clock select block.
`timescale 1ns/1ps
`default_nettype none
module scm_ext_src #(
  parameter real HALF_NS = 62.5
) (
  // Commands from the bench
  input wire logic run,
  input wire logic lock,
  // Pins towards the block
  output logic ext_clk_in,
  output logic pll_lock_in
);
  // A dead crystal leaves its pin parked at the last level; that is what the monitor must catch.
  initial ext_clk_in = 1'b0;
  always #(HALF_NS) if (run) ext_clk_in = ~ext_clk_in;
  assign pll_lock_in = lock;
endmodule // scm_ext_src
`default_nettype wire

// ### sim/scm_top_tb_top.sv
// Self-checking bench for the clock select block with its oscillator model.
`timescale 1ns/1ps
`default_nettype none
`include "scm_defs.vh"
module scm_top_tb_top;
  logic ref_clk, reset, hsel, hwrite, run, lock;
  logic [31:0] haddr, hwdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata;
  wire [1:0] sys_src;
  wire hreadyout, hresp, ext_clk_in, pll_lock_in, ext_osc_on, pll_on;
  wire rc_gate, ext_gate, pll_gate, motor_control_timer_pll_sel;
  wire ahb_tick, apb2_tick, apb1_tick, ext_fail_flag, irq;
  int miscompares, check_count, cyc;

  // Short ready count keeps the oscillator start-up inside a few dozen cycles.
  scm_top #(.READY_EDGES(8)) scm_top_i (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_clk_in,
    .pll_lock_in, .ext_osc_on, .pll_on, .rc_gate, .ext_gate, .pll_gate, .sys_src,
    .motor_control_timer_pll_sel, .ahb_tick, .apb2_tick, .apb1_tick, .ext_fail_flag, .irq);
  scm_ext_src scm_ext_src_i (.run, .lock, .ext_clk_in, .pll_lock_in);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic do_reset(input int n);
    reset <= 1'b1;
    repeat (n) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic t_reset;
    check(sys_src, `SCM_SRC_RC);
    check(rc_gate, 1'b1);
    check(ext_gate | pll_gate, 1'b0);
    check({hresp, hreadyout}, 32'h1);
    check({ext_fail_flag, irq, pll_on, ext_osc_on}, 32'h0);
    ahb(1'b0, `SCM_OFS_CTRL, 32'h0);
    check(q, 32'h0);
    ahb(1'b0, `SCM_OFS_DIV, 32'h0);
    check(q, 32'h0);
    ahb(1'b1, 8'h14, 32'hFFFFFFFF);
    ahb(1'b0, 8'h14, 32'h0);
    check(q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_ext_fail(input logic m);
    run <= 1'b1;
    ahb(1'b1, `SCM_OFS_IRQ_MASK, {31'h0, m});
    ahb(1'b1, `SCM_OFS_CTRL, 32'h07);
    repeat (400) if (sys_src !== `SCM_SRC_EXT) @(posedge ref_clk);
    check(ext_gate, 1'b1);
    ahb(1'b0, `SCM_OFS_IRQ_STAT, 32'h0);
    check(q & 32'h15, 32'h14);
    run <= 1'b0;
    repeat (200) if (ext_fail_flag !== 1'b1) @(posedge ref_clk);
    check(ext_fail_flag, 1'b1);
    @(posedge ref_clk);
    check(irq, m);
    repeat (20) @(posedge ref_clk);
    check(sys_src, `SCM_SRC_RC);
    check(rc_gate, 1'b1);
    check(ext_fail_flag, 1'b1);
    ahb(1'b0, `SCM_OFS_CTRL, 32'h0);
    check(q & 32'h0C, 32'h0);
    ahb(1'b0, `SCM_OFS_IRQ_STAT, 32'h0);
    check(q & 32'h11, 32'h11);
    @(posedge ref_clk);
    check(ext_fail_flag, 1'b0);
    check(irq, 1'b0);
    $display("test external clock failure done");
  endtask

  task automatic t_pll;
    int a, b, c;
    ahb(1'b1, `SCM_OFS_DIV, 32'h001);
    ahb(1'b1, `SCM_OFS_CTRL, 32'h18);
    // Lock arrives after the enable so the lock-gained event is exercised.
    lock <= 1'b1;
    repeat (400) if (sys_src !== `SCM_SRC_PLL) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    check(pll_gate, 1'b1);
    check(pll_on, 1'b1);
    check(motor_control_timer_pll_sel, 1'b1);
    ahb(1'b1, `SCM_OFS_DIV, 32'h321);
    repeat (4) @(posedge ref_clk);
    check(motor_control_timer_pll_sel, 1'b0);
    a = 0;
    b = 0;
    c = 0;
    repeat (64) begin
      @(posedge ref_clk);
      a += ahb_tick;
      b += apb2_tick;
      c += apb1_tick;
    end
    check(a, 32);
    check(b, 16);
    check(c, 8);
    ahb(1'b1, `SCM_OFS_IRQ_MASK, 32'h02);
    ahb(1'b0, `SCM_OFS_IRQ_STAT, 32'h0);
    check(q & 32'h18, 32'h18);
    lock <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check(irq, 1'b1);
    ahb(1'b0, `SCM_OFS_IRQ_STAT, 32'h0);
    check(q & 32'h02, 32'h02);
    $display("test pll and prescalers done");
  endtask

  task automatic t_pll_ext;
    lock <= 1'b1;
    run <= 1'b1;
    ahb(1'b1, `SCM_OFS_CTRL, 32'h3B);
    repeat (400) if (sys_src !== `SCM_SRC_PLL) @(posedge ref_clk);
    check(pll_gate, 1'b1);
    // Give the crystal time to qualify before it is stopped.
    repeat (60) @(posedge ref_clk);
    ahb(1'b0, `SCM_OFS_IRQ_STAT, 32'h0);
    check(q & 32'h1C, 32'h1C);
    run <= 1'b0;
    repeat (200) if (ext_fail_flag !== 1'b1) @(posedge ref_clk);
    check(ext_fail_flag, 1'b1);
    repeat (20) @(posedge ref_clk);
    check(sys_src, `SCM_SRC_RC);
    check(rc_gate, 1'b1);
    check(irq, 1'b1);
    ahb(1'b0, `SCM_OFS_CTRL, 32'h0);
    check(q & 32'h0C, 32'h0);
    ahb(1'b0, `SCM_OFS_IRQ_STAT, 32'h0);
    check(q & 32'h13, 32'h13);
    $display("test pll on external reference done");
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      results;
    end
  end

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    run = 1'b0;
    lock = 1'b0;
    cyc = 0;
    do_reset(5);
    t_reset;
    t_ext_fail(1'b1);
    t_ext_fail(1'b0);
    t_pll;
    t_pll_ext;
    do_reset(2);
    t_reset;
    results;
  end
endmodule // scm_top_tb_top
`default_nettype wire
